// ==== pkg/acs_pkg.sv ====
`default_nettype none

package acs_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses, one 32-bit word each)
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL_A = 8'h00;
    localparam logic [7:0] OFS_CTRL_B = 8'h04;
    localparam logic [7:0] OFS_RES_HI = 8'h08;
    localparam logic [7:0] OFS_RES_LO = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int A_ON = 0;
    localparam int A_GO = 1;
    localparam int A_CHS = 2;
    localparam int A_VREF = 6;
    localparam int A_JUST = 7;
    localparam int B_CKS = 4;
    localparam int ST_FLAG = 0;
    localparam int ST_IE = 1;
    localparam int ST_PWR = 2;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [3:0] CHS_RST = 4'h0;
    localparam logic [2:0] CKS_RST = 3'h0;
    localparam logic [7:0] RES_RST = 8'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CONV_TADS = 11;
    localparam int ABORT_TADS = 2;
    localparam int CLK_PERIOD_NS = 8;
    // One instruction cycle is four system clocks
    localparam int INSTR_CLKS = 4;
    localparam logic [1:0] CKS_FRC = 2'h3;
    localparam logic [5:0] DIV_MAX_2 = 6'h01;
    localparam logic [5:0] DIV_MAX_4 = 6'h03;
    localparam logic [5:0] DIV_MAX_8 = 6'h07;
    localparam logic [5:0] DIV_MAX_16 = 6'h0f;
    localparam logic [5:0] DIV_MAX_32 = 6'h1f;
    localparam logic [5:0] DIV_MAX_64 = 6'h3f;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DELAY = 2'b01,
        ST_CONV = 2'b11,
        ST_ABORT = 2'b10
    } acs_state_t;

    typedef struct packed {
        acs_state_t state;
        logic on;
        logic go;
        logic [3:0] channel_select;
        logic vref;
        logic just;
        logic [2:0] cks;
        logic flag;
        logic ie;
        logic off;
        logic [7:0] res_hi;
        logic [7:0] res_lo;
        logic [5:0] div_cnt;
        logic [3:0] tad_cnt;
        logic [1:0] ins_cnt;
        logic frc_s1;
        logic frc_s2;
        logic frc_s3;
        logic frc_lvl;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic pwr;
        logic sample;
        logic conv;
        logic wake;
        logic tbclr;
    } acs_regs_t;

endpackage : acs_pkg

`default_nettype wire

// ==== src/acs_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none

module acs_sequencer
    import acs_pkg::*;
#(
    parameter int CONV_TADS_P = CONV_TADS,
    parameter int ABORT_TADS_P = ABORT_TADS
)(
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [ADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic SLEEP_I,
    input wire logic TRIGGER_I,
    input wire logic FRC_CLK_I,
    input wire logic [9:0] CONV_DATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic [3:0] CHANNEL_O,
    output logic REF_SEL_O,
    output logic SAMPLE_O,
    output logic CONVERTING_O,
    output logic POWERED_O,
    output logic DONE_FLAG_O,
    output logic IRQ_ENABLE_O,
    output logic WAKE_O,
    output logic TIMEBASE_CLR_O
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (CONV_TADS_P < 2 || CONV_TADS_P > 15)
        $error("CONV_TADS_P must lie in 2..15");
    if (ABORT_TADS_P < 1 || ABORT_TADS_P > 15)
        $error("ABORT_TADS_P must lie in 1..15");

    localparam logic [3:0] CONV_LAST = 4'(CONV_TADS_P - 1);
    localparam logic [3:0] ABORT_LAST = 4'(ABORT_TADS_P - 1);
    localparam logic [1:0] INSTR_LAST = 2'(INSTR_CLKS - 1);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [5:0] tad_div_max(input logic [2:0] cks);
        logic [5:0] m;
        m = DIV_MAX_2;
        unique case (cks[1:0])
            2'b00: m = cks[2] ? DIV_MAX_4 : DIV_MAX_2;
            2'b01: m = cks[2] ? DIV_MAX_16 : DIV_MAX_8;
            2'b10: m = cks[2] ? DIV_MAX_64 : DIV_MAX_32;
            default: m = DIV_MAX_2;
        endcase
        return m;
    endfunction : tad_div_max

    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        return (a == OFS_CTRL_A) || (a == OFS_CTRL_B) ||
               (a == OFS_RES_HI) || (a == OFS_RES_LO) ||
               (a == OFS_STATUS);
    endfunction : addr_mapped

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta_r;
    logic rst_n_r;

    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    localparam acs_regs_t REGS_RST = '{
        state: ST_IDLE, on: 1'b0, go: 1'b0, channel_select: CHS_RST, vref: 1'b0,
        just: 1'b0, cks: CKS_RST, flag: 1'b0, ie: 1'b0, off: 1'b0,
        res_hi: RES_RST, res_lo: RES_RST, div_cnt: '0, tad_cnt: '0,
        ins_cnt: '0, frc_s1: 1'b0, frc_s2: 1'b0, frc_s3: 1'b0,
        frc_lvl: 1'b0, pready: 1'b0, pslverr: 1'b0, prdata: '0,
        pwr: 1'b0, sample: 1'b0, conv: 1'b0, wake: 1'b0, tbclr: 1'b0
    };

    acs_regs_t s_r;
    acs_regs_t s_nxt;

    always_comb
    begin
        logic is_frc;
        logic powered;
        logic frc_rise;
        logic tick;
        logic done;
        logic setup;
        logic access;
        logic wr_a;
        logic wr_b;
        logic wr_st;
        logic [31:0] rd;

        s_nxt = s_r;
        s_nxt.wake = 1'b0;
        s_nxt.tbclr = 1'b0;
        done = 1'b0;
        tick = 1'b0;
        rd = '0;
        frc_rise = (s_r.frc_s2 == s_r.frc_s3) && s_r.frc_s3 && !s_r.frc_lvl;
        is_frc = (s_r.cks[1:0] == CKS_FRC);
        powered = s_r.on && !s_r.off;
        setup = PSEL_I && !PENABLE_I;
        access = PSEL_I && PENABLE_I && s_r.pready;
        wr_a = access && PWRITE_I && (PADDR_I == OFS_CTRL_A);
        wr_b = access && PWRITE_I && (PADDR_I == OFS_CTRL_B);
        wr_st = access && PWRITE_I && (PADDR_I == OFS_STATUS);

        // RC clock arrives from its own oscillator: three stages,
        // a rising edge counts once the second and third stages agree
        s_nxt.frc_s1 = FRC_CLK_I;
        s_nxt.frc_s2 = s_r.frc_s1;
        s_nxt.frc_s3 = s_r.frc_s2;
        if (s_r.frc_s2 == s_r.frc_s3)
            s_nxt.frc_lvl = s_r.frc_s3;

        // --------------------------------------------------------------
        // Bit period timebase
        // --------------------------------------------------------------
        if (s_r.state == ST_CONV || s_r.state == ST_ABORT)
        begin
            if (is_frc)
                tick = frc_rise;
            else
                tick = (s_r.div_cnt == tad_div_max(s_r.cks));
            if (!is_frc)
                s_nxt.div_cnt = tick ? '0 : s_r.div_cnt + 6'h01;
        end
        else
            s_nxt.div_cnt = '0;

        // --------------------------------------------------------------
        // Sequencer
        // --------------------------------------------------------------
        unique case (s_r.state)
            ST_IDLE:
            begin
                if (s_r.go && powered)
                begin
                    s_nxt.tad_cnt = '0;
                    s_nxt.ins_cnt = '0;
                    // Extra instruction lets the sleep request land first
                    s_nxt.state = is_frc ? ST_DELAY : ST_CONV;
                end
            end
            ST_DELAY:
            begin
                s_nxt.ins_cnt = s_r.ins_cnt + 2'h1;
                if (s_r.ins_cnt == INSTR_LAST)
                    s_nxt.state = ST_CONV;
            end
            ST_CONV:
            begin
                if (tick)
                begin
                    if (s_r.tad_cnt == CONV_LAST)
                    begin
                        done = 1'b1;
                        s_nxt.go = 1'b0;
                        s_nxt.state = ST_IDLE;
                        if (s_r.just)
                        begin
                            s_nxt.res_hi = {6'h00, CONV_DATA_I[9:8]};
                            s_nxt.res_lo = CONV_DATA_I[7:0];
                        end
                        else
                        begin
                            s_nxt.res_hi = CONV_DATA_I[9:2];
                            s_nxt.res_lo = {CONV_DATA_I[1:0], 6'h00};
                        end
                    end
                    else
                        s_nxt.tad_cnt = s_r.tad_cnt + 4'h1;
                end
            end
            ST_ABORT:
            begin
                if (tick)
                begin
                    if (s_r.tad_cnt == ABORT_LAST)
                        s_nxt.state = ST_IDLE;
                    else
                        s_nxt.tad_cnt = s_r.tad_cnt + 4'h1;
                end
            end
        endcase

        // --------------------------------------------------------------
        // APB slave: one wait-free access phase, answer registered
        // --------------------------------------------------------------
        unique case (PADDR_I)
            OFS_CTRL_A:
                rd[7:0] = {s_r.just, s_r.vref, s_r.channel_select, s_r.go, s_r.on};
            OFS_CTRL_B: rd[B_CKS +: 3] = s_r.cks;
            OFS_RES_HI: rd[7:0] = s_r.res_hi;
            OFS_RES_LO: rd[7:0] = s_r.res_lo;
            OFS_STATUS:
                rd[ST_PWR:ST_FLAG] = {s_r.pwr, s_r.ie, s_r.flag};
            default: rd = '0;
        endcase
        s_nxt.pready = setup;
        s_nxt.pslverr = setup && !addr_mapped(PADDR_I);
        s_nxt.prdata = (setup && !PWRITE_I) ? rd : '0;

        if (wr_a)
        begin
            s_nxt.just = PWDATA_I[A_JUST];
            s_nxt.vref = PWDATA_I[A_VREF];
            s_nxt.channel_select = PWDATA_I[A_CHS +: 4];
            s_nxt.on = PWDATA_I[A_ON];
            s_nxt.off = 1'b0;
            // Start needs the converter already on before this write
            if (PWDATA_I[A_GO] && s_r.on && !s_r.go &&
                s_r.state == ST_IDLE)
                s_nxt.go = 1'b1;
            else if (!PWDATA_I[A_GO] && s_nxt.go)
            begin
                s_nxt.go = 1'b0;
                if (s_r.state != ST_IDLE)
                begin
                    // Partial result is dropped, results untouched
                    s_nxt.state = ST_ABORT;
                    s_nxt.tad_cnt = '0;
                    s_nxt.div_cnt = '0;
                end
            end
            if (!PWDATA_I[A_ON])
            begin
                s_nxt.go = 1'b0;
                s_nxt.state = ST_IDLE;
            end
        end
        if (wr_b)
            s_nxt.cks = PWDATA_I[B_CKS +: 3];
        if (wr_st)
            s_nxt.ie = PWDATA_I[ST_IE];

        // Set wins over a same-cycle clear
        s_nxt.flag = (s_r.flag && !(wr_st && PWDATA_I[ST_FLAG])) ||
                     done;

        // --------------------------------------------------------------
        // Hardware trigger
        // --------------------------------------------------------------
        if (TRIGGER_I)
        begin
            s_nxt.tbclr = 1'b1;
            if (powered && s_nxt.state == ST_IDLE && s_nxt.on)
                s_nxt.go = 1'b1;
        end

        // --------------------------------------------------------------
        // Sleep
        // --------------------------------------------------------------
        if (done && SLEEP_I)
        begin
            if (s_r.ie)
                s_nxt.wake = 1'b1;
            else
                s_nxt.off = 1'b1;
        end
        if (SLEEP_I && !is_frc && s_nxt.on)
        begin
            // Divided clocks stop in sleep, so nothing can finish
            s_nxt.go = 1'b0;
            s_nxt.state = ST_IDLE;
            s_nxt.off = 1'b1;
        end

        s_nxt.pwr = s_nxt.on && !s_nxt.off;
        s_nxt.sample = s_nxt.pwr && !s_nxt.go && s_nxt.state == ST_IDLE;
        s_nxt.conv = s_nxt.state == ST_CONV;
    end

    always_ff @(posedge CLK_I or negedge rst_n_r)
    begin
        if (!rst_n_r)
            s_r <= REGS_RST;
        else
            s_r <= s_nxt;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign PRDATA_O = s_r.prdata;
    assign PREADY_O = s_r.pready;
    assign PSLVERR_O = s_r.pslverr;
    assign CHANNEL_O = s_r.channel_select;
    assign REF_SEL_O = s_r.vref;
    assign SAMPLE_O = s_r.sample;
    assign CONVERTING_O = s_r.conv;
    assign POWERED_O = s_r.pwr;
    assign DONE_FLAG_O = s_r.flag;
    assign IRQ_ENABLE_O = s_r.ie;
    assign WAKE_O = s_r.wake;
    assign TIMEBASE_CLR_O = s_r.tbclr;

endmodule : acs_sequencer

`default_nettype wire

// ==== test/acs_properties.sv ====
`timescale 1ns/1ps
`default_nettype none

module acs_properties
    import acs_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [ADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic SLEEP_I,
    input wire logic TRIGGER_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic SAMPLE_O,
    input wire logic CONVERTING_O,
    input wire logic POWERED_O,
    input wire logic DONE_FLAG_O,
    input wire logic WAKE_O,
    input wire logic TIMEBASE_CLR_O
);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RSTN_I);

    // A firmware write of one to the done flag is the only legal clear
    wire logic flag_clr;
    assign flag_clr = PSEL_I && PENABLE_I && PWRITE_I &&
                      PADDR_I == OFS_STATUS && PWDATA_I[ST_FLAG];

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    a_ready_next: assert property (
        PSEL_I && !PENABLE_I |=> PREADY_O)
        else $error("no ready after setup");
    a_err_zero: assert property (
        PSLVERR_O |-> PREADY_O && PRDATA_O == 32'h0)
        else $error("error response malformed");
    a_trig_clr: assert property (
        TRIGGER_I |=> TIMEBASE_CLR_O)
        else $error("timebase clear missing");
    a_clr_cause: assert property (
        TIMEBASE_CLR_O |-> $past(TRIGGER_I))
        else $error("timebase clear without trigger");
    a_off_idle: assert property (
        !POWERED_O ##1 !POWERED_O |-> !CONVERTING_O)
        else $error("conversion while unpowered");
    a_flag_cause: assert property (
        $rose(DONE_FLAG_O) |-> $past(CONVERTING_O) && !CONVERTING_O)
        else $error("done flag outside completion");
    a_flag_hold: assert property (
        DONE_FLAG_O && !flag_clr |=> DONE_FLAG_O)
        else $error("done flag lost without clear");
    a_wake_cause: assert property (
        WAKE_O |-> $past(SLEEP_I) && DONE_FLAG_O)
        else $error("wake without sleep completion");
    a_conv_nosample: assert property (
        CONVERTING_O |-> !SAMPLE_O)
        else $error("sampling during conversion");
    a_abort_wait: assert property (
        $fell(CONVERTING_O) && !DONE_FLAG_O && POWERED_O
        |-> !SAMPLE_O ##1 !SAMPLE_O)
        else $error("acquisition before abort wait");

    c_done: cover property ($rose(DONE_FLAG_O));
    c_wake: cover property (WAKE_O);
    c_abort: cover property ($fell(CONVERTING_O) && !DONE_FLAG_O);

endmodule : acs_properties

bind acs_sequencer acs_properties acs_props_u (.CLK_I(CLK_I),
    .RSTN_I(RSTN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
    .SLEEP_I(SLEEP_I), .TRIGGER_I(TRIGGER_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .SAMPLE_O(SAMPLE_O),
    .CONVERTING_O(CONVERTING_O), .POWERED_O(POWERED_O),
    .DONE_FLAG_O(DONE_FLAG_O), .WAKE_O(WAKE_O),
    .TIMEBASE_CLR_O(TIMEBASE_CLR_O));

`default_nettype wire

// ==== test/adc_conversion_sequencer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module adc_conversion_sequencer_tb;
    import acs_pkg::*;
    logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0;
    logic slp = 0, trg = 0, frc = 0;
    logic [7:0] pa = 8'h00;
    logic [31:0] pwd = 32'h0, prd, rd;
    logic [9:0] cdata = 10'h2a5;
    logic [3:0] chan;
    logic pready, perr, refs, samp, conv, pwrd, flag, ie, wake, tclr, er;
    int error_cnt = 0, cmp_count = 0, n, wake_cnt = 0;
    // Rows: write, error, address, write data or expected read data
    localparam logic [41:0] ROWS [16] = '{
        {2'b00, OFS_CTRL_A, 32'h0}, {2'b00, OFS_CTRL_B, 32'h0},
        {2'b00, OFS_RES_HI, 32'h0}, {2'b00, OFS_RES_LO, 32'h0},
        {2'b00, OFS_STATUS, 32'h0}, {2'b01, 8'h14, 32'h0},
        {2'b11, 8'h14, 32'h1}, {2'b10, OFS_CTRL_A, 32'h83},
        {2'b00, OFS_CTRL_A, 32'h81}, {2'b00, OFS_STATUS, 32'h4},
        {2'b10, OFS_RES_HI, 32'hff}, {2'b00, OFS_RES_HI, 32'h0},
        {2'b10, OFS_CTRL_A, 32'h0}, {2'b10, OFS_CTRL_A, 32'h2},
        {2'b00, OFS_CTRL_A, 32'h0}, {2'b10, OFS_CTRL_A, 32'h81}};
    localparam logic [2:0] CKS [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};

    acs_sequencer dut_u (.CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd),
        .SLEEP_I(slp), .TRIGGER_I(trg), .FRC_CLK_I(frc),
        .CONV_DATA_I(cdata), .PRDATA_O(prd), .PREADY_O(pready),
        .PSLVERR_O(perr), .CHANNEL_O(chan), .REF_SEL_O(refs),
        .SAMPLE_O(samp), .CONVERTING_O(conv), .POWERED_O(pwrd),
        .DONE_FLAG_O(flag), .IRQ_ENABLE_O(ie), .WAKE_O(wake),
        .TIMEBASE_CLR_O(tclr));

    initial
    begin
        forever #4 clk = ~clk;
    end
    // RC oscillator runs free, unrelated to the system clock
    initial
    begin
        forever #20 frc = ~frc;
    end
    always @(posedge clk) if (wake === 1'b1) wake_cnt++;

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    // Called just after a rising edge; leaves one idle cycle behind
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("rdata", e, rd);
    endtask : rchk

    // Counts the cycles spent converting
    task automatic run(output int cyc);
        cyc = 0;
        while (conv !== 1'b1) @(posedge clk);
        while (conv === 1'b1)
        begin
            cyc++;
            @(posedge clk);
        end
    endtask : run

    task automatic print_verdict;
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict

    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (ROWS[i])
        begin
            apb(ROWS[i][41], ROWS[i][39:32], ROWS[i][31:0]);
            if (!ROWS[i][41]) chk("rdata", ROWS[i][31:0], rd);
            chk("slverr", {31'h0, ROWS[i][40]}, {31'h0, er});
        end
        // Slowest divider first so the run ends on the fastest one
        for (int k = 5; k >= 0; k--)
        begin
            apb(1'b1, OFS_CTRL_B, {25'h0, CKS[k], 4'h0});
            apb(1'b1, OFS_CTRL_A, 32'h83);
            run(n);
            chk("conv_len", 32'(CONV_TADS * (2 << k)), n);
        end
        rchk(OFS_CTRL_A, 32'h81);
        rchk(OFS_RES_HI, 32'h02);
        rchk(OFS_RES_LO, 32'ha5);
        rchk(OFS_STATUS, 32'h05);
        apb(1'b1, OFS_CTRL_A, 32'h01);
        trg <= 1'b1;
        @(posedge clk);
        trg <= 1'b0;
        @(posedge clk);
        chk("tb_clear", 32'h1, {31'h0, tclr});
        run(n);
        rchk(OFS_RES_HI, 32'ha9);
        rchk(OFS_RES_LO, 32'h40);
        rchk(OFS_STATUS, 32'h05);
        apb(1'b1, OFS_STATUS, 32'h01);
        rchk(OFS_STATUS, 32'h04);
        cdata <= 10'h0ff;
        apb(1'b1, OFS_CTRL_A, 32'h03);
        repeat (5) @(posedge clk);
        fork
            apb(1'b1, OFS_CTRL_A, 32'h01);
            begin
                while (conv === 1'b1) @(posedge clk);
                n = 0;
                while (samp !== 1'b1)
                begin
                    n++;
                    @(posedge clk);
                end
            end
        join
        chk("abort_gap", 32'(ABORT_TADS * 2), n);
        rchk(OFS_RES_HI, 32'ha9);
        rchk(OFS_RES_LO, 32'h40);
        rchk(OFS_STATUS, 32'h04);
        apb(1'b1, OFS_CTRL_A, 32'h03);
        while (conv !== 1'b1) @(posedge clk);
        slp <= 1'b1;
        repeat (3) @(posedge clk);
        chk("powered", 32'h0, {31'h0, pwrd});
        chk("converting", 32'h0, {31'h0, conv});
        rchk(OFS_CTRL_A, 32'h01);
        slp <= 1'b0;
        apb(1'b1, OFS_CTRL_A, 32'h01);
        chk("powered", 32'h1, {31'h0, pwrd});
        apb(1'b1, OFS_CTRL_B, 32'h30);
        apb(1'b1, OFS_STATUS, 32'h02);
        chk("irq_enable", 32'h1, {31'h0, ie});
        apb(1'b1, OFS_CTRL_A, 32'h03);
        slp <= 1'b1;
        repeat (3) @(posedge clk);
        chk("rc_delay", 32'h0, {31'h0, conv});
        run(n);
        repeat (2) @(posedge clk);
        chk("wake_cnt", 32'h1, wake_cnt);
        chk("powered", 32'h1, {31'h0, pwrd});
        slp <= 1'b0;
        apb(1'b1, OFS_STATUS, 32'h01);
        apb(1'b1, OFS_CTRL_A, 32'h03);
        slp <= 1'b1;
        run(n);
        repeat (2) @(posedge clk);
        chk("powered", 32'h0, {31'h0, pwrd});
        chk("wake_cnt", 32'h1, wake_cnt);
        slp <= 1'b0;
        rchk(OFS_CTRL_A, 32'h01);
        apb(1'b1, OFS_CTRL_A, 32'h5d);
        chk("channel", 32'h7, {28'h0, chan});
        chk("ref_sel", 32'h1, {31'h0, refs});
        apb(1'b1, OFS_CTRL_A, 32'h03);
        while (conv !== 1'b1) @(posedge clk);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        chk("converting", 32'h0, {31'h0, conv});
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        rchk(OFS_CTRL_A, 32'h0);
        rchk(OFS_CTRL_B, 32'h0);
        rchk(OFS_RES_HI, 32'h0);
        rchk(OFS_STATUS, 32'h0);
        print_verdict();
    end

endmodule : adc_conversion_sequencer_tb

`default_nettype wire
